// ---- hw/pss_sequencer.sv ----
// Purpose: Four-phase instruction sequencer, program counter and return stack.
// Assumes: Decoder, program memory and interrupt logic share clk.
// Notes:   Program memory answers a fetch before the last phase of the cycle.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pss_sequencer
#(
  parameter logic [11:0] RESET_VECTOR = pss_pkg::PSS_RESET_VEC
)
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // Program memory
  output var  pss_pkg::pss_fetch_t           fetch,
  input  wire logic [pss_pkg::PSS_IR_W-1:0]  fetch_data,
  // Decoder side
  output var  logic [pss_pkg::PSS_IR_W-1:0]  exec_ir,
  output var  logic                          exec_valid,
  input  wire pss_pkg::pss_ctl_t             ctl,
  output var  logic [3:0]                    four_clock_phases,
  // Interrupt logic
  input  wire logic                          irq_req,
  input  wire logic [pss_pkg::PSS_PC_W-1:0]  irq_vector,
  output var  logic                          irq_ack,
  output var  logic                          irq_pending
);
  import pss_pkg::*;

  // ==========================================================
  // State
  logic [3:0]          phase_r;
  logic [PSS_PC_W-1:0] pc_r;
  logic [PSS_PC_W-1:0] fetch_addr_r;
  logic                fetch_req_r;
  logic [PSS_IR_W-1:0] exec_ir_r;
  logic                exec_valid_r;
  logic [PSS_PC_W-1:0] stack_r [PSS_DEPTH];
  logic [PSS_LVL_W-1:0] stack_level_index_r;
  logic [PSS_CNT_W-1:0] depth_r;
  logic                irq_pend_r;
  logic                irq_ack_r;
  logic                clb_pend_r;
  logic [7:0]          clb_val_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;

  // ==========================================================
  // Flow decision at the end of each instruction cycle
  logic                last_ph;
  logic                do_push;
  logic                do_pop;
  logic                do_irq;
  logic                redirect;
  logic [PSS_PC_W-1:0] pc_nxt;
  logic [PSS_PC_W-1:0] push_val;
  logic [PSS_LVL_W-1:0] top_idx;
  logic                stack_full;
  logic                clb_take;

  assign last_ph    = phase_r[PSS_PH_LAST];
  assign top_idx    = stack_level_index_r - 2'h1;
  assign stack_full = (depth_r == PSS_CNT_W'(PSS_DEPTH));
  // Return address is the prefetched word, which is the one after the call
  assign push_val   = fetch_addr_r;

  always_comb
  begin
    do_push  = 1'b0;
    do_pop   = 1'b0;
    do_irq   = 1'b0;
    clb_take = 1'b0;
    redirect = 1'b0;
    pc_nxt   = pc_r;
    if (last_ph && exec_valid_r)
    begin
      case (ctl.op)
        PSS_OP_JUMP:
        begin
          redirect = 1'b1;
          pc_nxt   = ctl.target;
        end
        PSS_OP_CALL:
        begin
          redirect = 1'b1;
          do_push  = 1'b1;
          pc_nxt   = ctl.target;
        end
        PSS_OP_SUB_RET, PSS_OP_INT_RET:
        begin
          redirect = 1'b1;
          do_pop   = 1'b1;
          pc_nxt   = stack_r[top_idx];
        end
        PSS_OP_SKIP:
          redirect = ctl.skip_taken;
        default:
          redirect = 1'b0;
      endcase
    end
    // Software page jump waits for an instruction boundary
    if (last_ph && !redirect && clb_pend_r)
    begin
      redirect = 1'b1;
      clb_take = 1'b1;
      pc_nxt   = {fetch_addr_r[PSS_PC_W-1:8], clb_val_r};
    end
    // Interrupt only between plain instructions; full stack holds it off
    else if (last_ph && !redirect && irq_pend_r && !stack_full)
    begin
      redirect = 1'b1;
      do_irq   = 1'b1;
      do_push  = 1'b1;
      pc_nxt   = irq_vector;
    end
  end

  // ==========================================================
  // Phase generator
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phase_r <= PSS_PH_RST;
    else
      phase_r <= {phase_r[PSS_PHASES-2:0], phase_r[PSS_PHASES-1]};
  end

  // ==========================================================
  // Program counter and fetch
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pc_r         <= RESET_VECTOR;
      fetch_addr_r <= RESET_VECTOR;
      fetch_req_r  <= 1'b0;
    end
    else
    begin
      fetch_req_r <= phase_r[PSS_PH_FETCH];
      if (phase_r[PSS_PH_FETCH])
      begin
        fetch_addr_r <= pc_r;
        pc_r         <= pc_r + 12'h001;
      end
      else if (redirect)
        pc_r <= pc_nxt;
    end
  end

  // ==========================================================
  // Execute stage; a redirect turns the prefetched word into a dummy
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      exec_ir_r    <= '0;
      exec_valid_r <= 1'b0;
    end
    else if (last_ph)
    begin
      exec_ir_r    <= fetch_data;
      exec_valid_r <= !redirect;
    end
  end

  // ==========================================================
  // Return stack, invisible to software
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stack_level_index_r <= PSS_LVL_RST;
      depth_r             <= PSS_CNT_RST;
    end
    else if (do_push)
    begin
      // Index wraps, so a push on a full stack lands on the oldest entry
      stack_level_index_r <= stack_level_index_r + 2'h1;
      if (!stack_full)
        depth_r <= depth_r + 3'h1;
    end
    else if (do_pop)
    begin
      stack_level_index_r <= top_idx;
      if (depth_r != PSS_CNT_RST)
        depth_r <= depth_r - 3'h1;
    end
  end

  // No reset on the array: contents are dead until pushed
  always_ff @(posedge clk)
  begin
    if (do_push)
      stack_r[stack_level_index_r] <= push_val;
  end

  // ==========================================================
  // Interrupt request latch; a new request wins over the acknowledge clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_pend_r <= 1'b0;
      irq_ack_r  <= 1'b0;
    end
    else
    begin
      irq_ack_r <= do_irq;
      if (irq_req)
        irq_pend_r <= 1'b1;
      else if (do_irq)
        irq_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave: one wait state, answer from flops
  logic apb_acc;
  logic apb_done;
  logic apb_hit;

  assign apb_acc  = psel && penable;
  assign apb_done = apb_acc && pready_r;
  assign apb_hit  = (paddr == PSS_ADDR_CLB) || (paddr == PSS_ADDR_STAT);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else if (apb_acc && !pready_r)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= !apb_hit;
      prdata_r  <= '0;
      if (!pwrite && paddr == PSS_ADDR_CLB)
        prdata_r <= {24'h000000, fetch_addr_r[7:0]};
      else if (!pwrite && paddr == PSS_ADDR_STAT)
        prdata_r <= {20'h00000, pc_r[PSS_PC_W-1:8], 4'h0, phase_r};
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Page jump request; a new write in the applying cycle is kept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clb_pend_r <= 1'b0;
      clb_val_r  <= 8'h00;
    end
    else if (apb_done && pwrite && paddr == PSS_ADDR_CLB)
    begin
      clb_pend_r <= 1'b1;
      clb_val_r  <= pwdata[7:0];
    end
    else if (clb_take)
      clb_pend_r <= 1'b0;
  end

  // ==========================================================
  // Outputs
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign fetch.req         = fetch_req_r;
  assign fetch.addr        = fetch_addr_r;
  assign exec_ir           = exec_ir_r;
  assign exec_valid        = exec_valid_r;
  assign four_clock_phases = phase_r;
  assign irq_ack           = irq_ack_r;
  assign irq_pending       = irq_pend_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_fetch_gap;
    !fetch_req_r [*3] ##1 fetch_req_r;
  endsequence

  a_phase_onehot: assert property ($onehot(phase_r))
    else $error("phase vector not one-hot");
  a_fetch_once_cycle: assert property (fetch_req_r |=> s_fetch_gap)
    else $error("fetch not once per instruction cycle");
  a_pc_advance_one: assert property (phase_r[0] |=> pc_r == $past(pc_r) + 12'h001)
    else $error("counter did not advance by one");
  a_redirect_flush: assert property (redirect |=> !exec_valid_r)
    else $error("redirect did not flush prefetch");
  a_jump_target: assert property (redirect |=> ##1 fetch_addr_r == $past(pc_nxt, 2))
    else $error("fetch did not resume at target");
  a_push_depth: assert property (do_push && !stack_full |=> depth_r == $past(depth_r) + 3'h1)
    else $error("push did not raise depth");
  a_pop_restore: assert property (do_pop |=> pc_r == $past(stack_r[top_idx]))
    else $error("return did not restore counter");
  a_full_no_ack: assert property (stack_full |=> !irq_ack_r)
    else $error("interrupt acknowledged with full stack");
  a_page_kept: assert property (clb_take |=> pc_r[11:8] == $past(fetch_addr_r[11:8]))
    else $error("page bits changed on low byte jump");
  a_overflow_wrap: assert property (do_push && stack_full
    |=> stack_level_index_r == $past(stack_level_index_r) + 2'h1 && stack_full)
    else $error("overflow did not wrap index");

endmodule : pss_sequencer
`default_nettype wire

// ---- hw/pss_pkg.sv ----
// Purpose: Constants and carrier types of the program sequencer and return stack.
// Assumes: One 50 MHz clock; APB register access.
// Notes:   Functional notes below.
package pss_pkg;

  localparam int          PSS_PC_W      = 12;
  localparam int          PSS_IR_W      = 15;
  localparam int          PSS_DEPTH     = 4;
  localparam int          PSS_LVL_W     = 2;
  localparam int          PSS_CNT_W     = 3;
  localparam int          PSS_PHASES    = 4;

  // Register byte addresses
  localparam logic [11:0] PSS_ADDR_CLB  = 12'h000;
  localparam logic [11:0] PSS_ADDR_STAT = 12'h004;

  // Reset values
  localparam logic [11:0] PSS_RESET_VEC = 12'h000;
  localparam logic [3:0]  PSS_PH_RST    = 4'h1;
  localparam logic [2:0]  PSS_CNT_RST   = 3'h0;
  localparam logic [1:0]  PSS_LVL_RST   = 2'h0;

  // Phase positions inside the one-hot phase vector
  localparam int          PSS_PH_FETCH  = 0;
  localparam int          PSS_PH_LAST   = 3;

  typedef enum logic [2:0] {
    PSS_OP_SEQ,
    PSS_OP_JUMP,
    PSS_OP_CALL,
    PSS_OP_SUB_RET,
    PSS_OP_INT_RET,
    PSS_OP_SKIP
  } pss_op_t;

  // Decoder verdict for the executing instruction, sampled in the last phase
  typedef struct packed {
    pss_op_t               op;
    logic                  skip_taken;
    logic [PSS_PC_W-1:0]   target;
  } pss_ctl_t;

  typedef struct packed {
    logic                  req;
    logic [PSS_PC_W-1:0]   addr;
  } pss_fetch_t;

endpackage : pss_pkg

// ---- tb/pss_mem_model.sv ----
// Purpose: Program memory and interrupt source beside the sequencer.
// Assumes: Same clock and reset as the sequencer.
// Notes:   Each word is a fixed mix of its address, so a wrong fetch shows.
`timescale 1ns/100ps
`default_nettype none
module pss_mem_model
  import pss_pkg::*;
#(
  parameter logic [11:0] VECTOR = 12'h040
)
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // Fetch port
  input  wire pss_pkg::pss_fetch_t          fetch,
  output var  logic [pss_pkg::PSS_IR_W-1:0] fetch_data,
  // Interrupt source
  input  wire logic                         irq_fire,
  output var  logic                         irq_req,
  output var  logic [11:0]                  irq_vector
);
  logic fire_q;
  assign fetch_data = {3'h5, fetch.addr ^ 12'hA5A};
  assign irq_vector = VECTOR;
  // One pulse per raise, however long the bench holds the level
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      fire_q  <= 1'b0;
      irq_req <= 1'b0;
    end
    else
    begin
      fire_q  <= irq_fire;
      irq_req <= irq_fire & ~fire_q;
    end
endmodule : pss_mem_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the sequencer against a cycle model.
// Assumes: The bench plays the decoder through ctl.
// Notes:   The model steps once per instruction cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pss_pkg::*;
  localparam logic [11:0] VEC = 12'h040;
  // ==========
  // Signals and model state
  logic        clk = 1'b0, resetn = 1'b0, irq_fire = 1'b0, ev, pend, e;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic        exec_valid, irq_req, irq_ack, irq_pending;
  logic [11:0] paddr = 12'h000, irq_vector, fa, ea, t;
  logic [11:0] stk [4];
  logic [31:0] pwdata = 32'h0, prdata, r, lfsr_state = 32'h00500606;
  logic [14:0] fetch_data, exec_ir;
  logic [3:0]  four_clock_phases;
  pss_fetch_t  fetch;
  pss_ctl_t    ctl = '0;
  int          num_errors = 0, comparisons = 0, sp, depth, clb, acks = 0, acks_exp = 0, tick;
  always #10 clk = ~clk;
  pss_sequencer #(.RESET_VECTOR(PSS_RESET_VEC)) DUT (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fetch, .fetch_data, .exec_ir,
    .exec_valid, .ctl, .four_clock_phases, .irq_req, .irq_vector, .irq_ack, .irq_pending);
  pss_mem_model #(.VECTOR(VEC)) MEM (.clk, .resetn, .fetch, .fetch_data, .irq_fire,
    .irq_req, .irq_vector);
  // ==========
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task give_verdict;
    $display("Counts: %0d compared, %0d mismatched", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task done(input string s);
    $display("Test %s finished", s);
  endtask : done
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task rnd;
    lfsr_state = lfsr(lfsr_state);
    t = lfsr_state[11:0];
  endtask : rnd
  task push(input logic [11:0] v);
    stk[sp] = v;
    sp = (sp + 1) % 4;
    if (depth < 4) depth++;
  endtask : push
  function logic [11:0] pop;
    sp = (sp + 3) % 4;
    if (depth > 0) depth--;
    return stk[sp];
  endfunction : pop
  task automatic wait_ph(input logic [3:0] p);
    int n = 0;
    do @(posedge clk); while (four_clock_phases !== p && ++n < 64);
  endtask : wait_ph
  // Phase vector is one-hot and rotates once per clock
  always @(posedge clk)
    if (resetn !== 1'b1)
      tick = 0;
    else
    begin
      chk(four_clock_phases, 32'h1 << (tick % 4));
      tick++;
    end
  always @(posedge clk)
    if (irq_ack === 1'b1) acks++;
  // ==========
  // One instruction cycle: compare, hand over the verdict, step the model
  task automatic instr(input pss_op_t op, input logic sk = 1'b0, input logic [11:0] tg = 12'h000);
    wait_ph(4'h4);
    chk(fetch.addr, fa);
    chk({exec_valid, irq_pending}, {ev, pend});
    if (ev) chk(exec_ir, {3'h5, ea ^ 12'hA5A});
    ctl <= '{op: op, skip_taken: sk, target: tg};
    wait_ph(4'h8);
    ctl <= '0;
    if (ev && op == PSS_OP_CALL) push(fa);
    if (ev && op inside {PSS_OP_JUMP, PSS_OP_CALL})
      fa = tg;
    else if (ev && op inside {PSS_OP_SUB_RET, PSS_OP_INT_RET})
      fa = pop();
    else if (ev && op == PSS_OP_SKIP && sk)
      fa = fa + 12'h001;
    else if (clb >= 0)
    begin
      fa = {fa[11:8], clb[7:0]};
      clb = -1;
    end
    else if (pend && depth < 4)
    begin
      push(fa);
      fa = VEC;
      pend = 1'b0;
      acks_exp++;
    end
    else
    begin
      ea = fa;
      fa = fa + 12'h001;
      ev = 1'b1;
      return;
    end
    ev = 1'b0;
  endtask : instr
  task automatic calls(input int n);
    for (int i = 0; i < n; i++)
    begin
      rnd();
      instr(PSS_OP_CALL, 1'b0, t);
      instr(PSS_OP_SEQ);
    end
  endtask : calls
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wait_ph(4'h8);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bus transfer while the pipeline keeps running under the model
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic [11:0] lo, hi;
    fork
      apb(w, a, d);
      begin
        instr(PSS_OP_SEQ);
        lo = fa;
        hi = lo + 12'h001;
        if (w && a == PSS_ADDR_CLB) clb = d[7:0];
        instr(PSS_OP_SEQ);
      end
    join
    chk(e, a > PSS_ADDR_STAT);
    if (!w) chk(r, e ? 32'h0 : (a == PSS_ADDR_STAT) ? {20'h0, hi[11:8], 8'h02} : {24'h0, lo[7:0]});
  endtask : bus
  task do_reset;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    chk(fetch, {1'b0, PSS_RESET_VEC});
    chk({exec_valid, irq_pending, pready, pslverr}, 4'h0);
    resetn <= 1'b1;
    fa = PSS_RESET_VEC;
    ev = 1'b0;
    pend = 1'b0;
    sp = 0;
    depth = 0;
    clb = -1;
  endtask : do_reset
  task raise_irq;
    irq_fire <= 1'b1;
    @(posedge clk);
    irq_fire <= 1'b0;
    pend = 1'b1;
  endtask : raise_irq
  // ==========
  // Main sequence
  initial
  begin
    do_reset();
    done("reset");
    repeat (4) instr(PSS_OP_SEQ);
    instr(PSS_OP_SKIP, 1'b0);
    instr(PSS_OP_SKIP, 1'b1);
    repeat (3) instr(PSS_OP_SEQ);
    rnd();
    instr(PSS_OP_JUMP, 1'b0, t);
    repeat (3) instr(PSS_OP_SEQ);
    done("sequence skip jump");
    calls(5);
    for (int i = 0; i < 5; i++)
    begin
      instr(i[0] ? PSS_OP_INT_RET : PSS_OP_SUB_RET);
      repeat (2) instr(PSS_OP_SEQ);
    end
    done("stack overflow");
    rnd();
    bus(1'b1, PSS_ADDR_CLB, lfsr_state);
    repeat (3) instr(PSS_OP_SEQ);
    bus(1'b0, PSS_ADDR_CLB, 32'h0);
    bus(1'b0, PSS_ADDR_STAT, 32'h0);
    bus(1'b1, 12'h008, lfsr_state);
    bus(1'b0, 12'h008, 32'h0);
    instr(PSS_OP_SEQ);
    done("counter low byte");
    calls(2);
    do_reset();
    calls(3);
    raise_irq();
    repeat (3) instr(PSS_OP_SEQ);
    instr(PSS_OP_INT_RET);
    repeat (2) instr(PSS_OP_SEQ);
    calls(1);
    raise_irq();
    repeat (3) instr(PSS_OP_SEQ);
    instr(PSS_OP_SUB_RET);
    repeat (3) instr(PSS_OP_SEQ);
    instr(PSS_OP_INT_RET);
    repeat (2) instr(PSS_OP_SEQ);
    chk(acks, acks_exp);
    done("interrupt");
    give_verdict();
  end
  initial
  begin
    #50000;
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
